// File: rtl/sblc_consts.vh
// Constants for the synthesiser bus and lock control block
`ifndef SBLC_CONSTS_VH
`define SBLC_CONSTS_VH
`define SBLC_TYPE_SLEEP   2'h0
`define SBLC_TYPE_NORMAL  2'h1
`define SBLC_TYPE_SETUP   2'h2
`define SBLC_TYPE_TEST    2'h3
`define SBLC_DUMMY_NIBBLE 4'hF
`define SBLC_WIN_SHORT    7'h50
`define SBLC_WIN_LONG     7'h54
`define SBLC_PREAMBLE_HI  4'hA
`define SBLC_DOUT_SLEEP   8'h0C
`define SBLC_DOUT_RESET   8'h00
`define SBLC_OE_SLEEP     9'h110
`define SBLC_OE_DRIVE     9'h000
`define SBLC_THRESH_RESET 7'h00
`define SBLC_WSEL_B       2'h1
`define SBLC_WSEL_C       2'h2
`define SBLC_WSEL_D       2'h3
`define SBLC_PHASE_WIN    2'h2
`endif

// File: rtl/sblc_loop_lock.v
// Per-loop phase window check with whole-period unlock hold
`timescale 1ns/10ps
module sblc_loop_lock (
  input  wire core_clk_i,
  input  wire rstn_i,
  input  wire ref_edge_i,
  input  wire div_edge_i,
  output reg  lock_o
);
`include "sblc_consts.vh"
  reg [1:0] gap;
  reg       open;
  reg       fail;
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gap  <= 2'h0;
      open <= 1'b0;
      fail <= 1'b0;
      lock_o <= 1'b0;
    end else begin
      if (ref_edge_i ^ div_edge_i) begin
        if (open) begin
          open <= 1'b0;
        end else begin
          open <= 1'b1;
          gap  <= 2'h0;
        end
      end else if (open) begin
        if (gap == `SBLC_PHASE_WIN) begin
          fail <= 1'b1;
        end else begin
          gap <= gap + 2'h1;
        end
      end
      // Result of a comparison period applied at the next reference edge
      if (ref_edge_i) begin
        lock_o <= ~fail & ~(open & (gap == `SBLC_PHASE_WIN));
        fail   <= 1'b0;
      end
    end
  end
endmodule

// File: rtl/sblc_top.v
// Synthesiser bus capture, radio command decode and lock detect filter
`timescale 1ns/10ps
module sblc_top (
  input  wire        core_clk_i,
  input  wire        rstn_i,
  input  wire        bus_serial_clock_i,
  input  wire        serial_data_i,
  input  wire        synth_latch_strobe_i,
  input  wire        cmd_valid_i,
  input  wire [7:0]  cmd_payload_byte_i,
  input  wire [7:0]  cmd_second_byte_i,
  input  wire [7:0]  cmd_third_byte_i,
  input  wire        crystal_reference_clock_i,
  input  wire        main_ref_edge_i,
  input  wire        main_div_edge_i,
  input  wire        aux_ref_edge_i,
  input  wire        aux_div_edge_i,
  input  wire        main_reload_i,
  input  wire        aux_reload_i,
  output reg  [11:0] main_low_modulus_count_o,
  output reg  [7:0]  main_high_modulus_count_o,
  output reg  [2:0]  frac_numerator_o,
  output reg  [7:0]  pump_scale_coeff_o,
  output reg  [3:0]  speedup_int_mult_o,
  output reg  [1:0]  speedup_prop_exp_o,
  output reg  [11:0] aux_vco_divider_o,
  output reg  [11:0] reference_divider_o,
  output reg  [1:0]  main_compare_freq_sel_o,
  output reg         main_standby_bit_o,
  output reg  [1:0]  aux_compare_freq_sel_o,
  output reg         aux_standby_bit_o,
  output reg         frac_denominator_sel_o,
  output reg         long_word_select_o,
  output wire        speedup_active_o,
  output reg         sleep_o,
  output reg         xtal_osc_on_o,
  output reg         clk_out_osc_on_o,
  output reg         mult_default_o,
  output reg  [7:0]  dout_level_o,
  output reg  [8:0]  dout_oe_n_o,
  output reg         dout8_ref_on_o,
  output reg  [7:0]  preamble_o,
  output reg         preamble_valid_o,
  output wire        lock_combined_o
);
`include "sblc_consts.vh"
  // Pin inputs pass two flip-flops
  reg [1:0] clk_sync;
  reg [1:0] dat_sync;
  reg [1:0] stb_sync;
  reg [1:0] xo_sync;
  reg       clk_prev;
  reg       stb_prev;
  reg       xo_prev;
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clk_sync <= 2'h0;
      dat_sync <= 2'h0;
      // Strobe idles high; a low reset value would fake a latch edge
      stb_sync <= 2'h3;
      xo_sync  <= 2'h0;
      clk_prev <= 1'b0;
      stb_prev <= 1'b1;
      xo_prev  <= 1'b0;
    end else begin
      clk_sync <= {clk_sync[0], bus_serial_clock_i};
      dat_sync <= {dat_sync[0], serial_data_i};
      stb_sync <= {stb_sync[0], synth_latch_strobe_i};
      xo_sync  <= {xo_sync[0], crystal_reference_clock_i};
      clk_prev <= clk_sync[1];
      stb_prev <= stb_sync[1];
      xo_prev  <= xo_sync[1];
    end
  end
  wire clk_rise = clk_sync[1] & ~clk_prev;
  wire stb_rise = stb_sync[1] & ~stb_prev;
  wire xo_rise  = xo_sync[1] & ~xo_prev;

  // Keeps the last 34 bits so the long word's scale byte clears the counts
  reg  [33:0] shreg;
  reg  [5:0]  nbits;
  reg         speedup;
  // Pending word B fields
  reg  [7:0]  pend_scale;
  reg  [3:0]  pend_int;
  reg  [1:0]  pend_prop;
  // Channel values waiting for divider reload
  reg  [11:0] stage_low;
  reg  [7:0]  stage_high;
  reg  [2:0]  stage_frac;
  reg  [11:0] stage_aux;
  reg  [11:0] stage_ref;
  wire [1:0]  wsel   = shreg[1:0];
  wire        dummy  = (shreg[3:0] == `SBLC_DUMMY_NIBBLE);
  // A strobe pulse with no bits shifted must not apply the old word again
  wire        fresh  = (nbits != 6'h0);
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shreg <= 34'h0;
      nbits <= 6'h0;
      speedup <= 1'b0;
      pend_scale <= 8'h00;
      pend_int <= 4'h0;
      pend_prop <= 2'h0;
      stage_low <= 12'h003;
      stage_high <= 8'h01;
      stage_frac <= 3'h0;
      stage_aux <= 12'h003;
      stage_ref <= 12'h008;
      main_low_modulus_count_o <= 12'h003;
      main_high_modulus_count_o <= 8'h01;
      frac_numerator_o <= 3'h0;
      pump_scale_coeff_o <= 8'h00;
      speedup_int_mult_o <= 4'h0;
      speedup_prop_exp_o <= 2'h0;
      aux_vco_divider_o <= 12'h003;
      reference_divider_o <= 12'h008;
      main_compare_freq_sel_o <= 2'h0;
      main_standby_bit_o <= 1'b1;
      aux_compare_freq_sel_o <= 2'h0;
      aux_standby_bit_o <= 1'b1;
      frac_denominator_sel_o <= 1'b0;
      long_word_select_o <= 1'b0;
    end else begin
      if (stb_rise) begin
        nbits <= 6'h0;
      end else if (clk_rise && !stb_sync[1]) begin
        shreg <= {shreg[32:0], dat_sync[1]};
        if (nbits != 6'h3F) begin
          nbits <= nbits + 6'h1;
        end
      end
      if (!stb_sync[1]) begin
        speedup <= 1'b0;
      end
      if (stb_rise && !dummy && fresh) begin
        case (wsel)
          2'h0: begin
            speedup <= 1'b1;
            stage_low  <= shreg[25:14];
            stage_high <= shreg[13:6];
            stage_frac <= shreg[5:3];
            pump_scale_coeff_o <= pend_scale;
            speedup_int_mult_o <= pend_int;
            speedup_prop_exp_o <= pend_prop;
            if (long_word_select_o) begin
              pump_scale_coeff_o <= shreg[33:26];
            end
          end
          `SBLC_WSEL_B: begin
            pend_scale <= shreg[23:16];
            pend_int   <= shreg[15:12];
            pend_prop  <= shreg[11:10];
          end
          `SBLC_WSEL_C: begin
            stage_aux <= shreg[25:14];
            stage_ref <= shreg[13:2];
          end
          default: begin
            main_compare_freq_sel_o <= shreg[9:8];
            main_standby_bit_o <= shreg[7];
            aux_compare_freq_sel_o <= shreg[6:5];
            aux_standby_bit_o <= shreg[4];
            frac_denominator_sel_o <= shreg[3];
            long_word_select_o <= shreg[2];
          end
        endcase
      end
      if (main_reload_i) begin
        main_low_modulus_count_o <= stage_low;
        main_high_modulus_count_o <= stage_high;
        frac_numerator_o <= stage_frac;
      end
      if (aux_reload_i) begin
        aux_vco_divider_o <= stage_aux;
      end
      // Shared reference divider takes its new ratio at either loop's reload
      if (main_reload_i | aux_reload_i) begin
        reference_divider_o <= stage_ref;
      end
    end
  end
  assign speedup_active_o = speedup & stb_sync[1];

  // Radio interface command decode
  wire [1:0] ctype   = cmd_second_byte_i[7:6];
  wire       is_norm = cmd_valid_i & (ctype == `SBLC_TYPE_NORMAL);
  wire       is_set  = cmd_valid_i & (ctype == `SBLC_TYPE_SETUP);
  wire       is_slp  = cmd_valid_i & (ctype == `SBLC_TYPE_SLEEP);
  wire       restart = is_set & (cmd_third_byte_i[1:0] == 2'h3);
  reg  [7:0] dout_reg;
  reg        dout8_reg;
  reg  [6:0] lock_thresh;
  reg        win_long;
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sleep_o <= 1'b1;
      xtal_osc_on_o <= 1'b1;
      clk_out_osc_on_o <= 1'b1;
      mult_default_o <= 1'b1;
      dout_reg <= `SBLC_DOUT_RESET;
      dout8_reg <= 1'b0;
      lock_thresh <= `SBLC_THRESH_RESET;
      win_long <= 1'b0;
    end else if (restart) begin
      sleep_o <= 1'b1;
      xtal_osc_on_o <= 1'b1;
      clk_out_osc_on_o <= 1'b1;
      mult_default_o <= 1'b1;
      dout_reg <= `SBLC_DOUT_RESET;
      dout8_reg <= 1'b0;
      lock_thresh <= `SBLC_THRESH_RESET;
      win_long <= 1'b0;
    end else begin
      if (is_slp) begin
        sleep_o <= 1'b1;
      end
      if (is_norm) begin
        sleep_o <= 1'b0;
        dout8_reg <= cmd_third_byte_i[5];
        if (cmd_second_byte_i[2]) begin
          dout_reg <= cmd_payload_byte_i;
        end
        if (cmd_second_byte_i[4]) begin
          lock_thresh <= cmd_payload_byte_i[7:1];
        end
      end
      if (is_set) begin
        xtal_osc_on_o <= cmd_third_byte_i[7];
        clk_out_osc_on_o <= cmd_second_byte_i[0];
        if (cmd_third_byte_i[5]) begin
          win_long <= cmd_payload_byte_i[5];
          mult_default_o <= 1'b0;
        end
      end
    end
  end

  // Output pins; enables are low while driven
  always @* begin
    if (sleep_o) begin
      dout_level_o = `SBLC_DOUT_SLEEP;
      dout_oe_n_o  = `SBLC_OE_SLEEP;
      dout8_ref_on_o = 1'b0;
    end else begin
      dout_level_o = dout_reg;
      dout_oe_n_o  = `SBLC_OE_DRIVE;
      dout8_ref_on_o = dout8_reg;
    end
  end

  // Lock detection per loop
  wire main_lock;
  wire aux_lock;
  sblc_loop_lock u_main_lock (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .ref_edge_i (main_ref_edge_i & xo_rise),
    .div_edge_i (main_div_edge_i & xo_rise),
    .lock_o     (main_lock)
  );
  sblc_loop_lock u_aux_lock (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .ref_edge_i (aux_ref_edge_i & xo_rise),
    .div_edge_i (aux_div_edge_i & xo_rise),
    .lock_o     (aux_lock)
  );
  assign lock_combined_o = ~(main_standby_bit_o & aux_standby_bit_o) &
                           (main_standby_bit_o | main_lock) &
                           (aux_standby_bit_o | aux_lock);

  // Filter: sample on every second bus clock rising edge
  reg       half;
  reg [6:0] hi_cnt;
  reg [6:0] win_cnt;
  reg       lock_filt;
  wire [6:0] win_len  = win_long ? `SBLC_WIN_LONG : `SBLC_WIN_SHORT;
  wire       win_last = (win_cnt == win_len - 7'h1);
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      half <= 1'b0;
      hi_cnt <= 7'h00;
      win_cnt <= 7'h00;
      lock_filt <= 1'b0;
    end else if (clk_rise) begin
      half <= ~half;
      if (half) begin
        if (win_last) begin
          // Last sample still counts toward the result
          lock_filt <= ({1'b0, hi_cnt} + {7'h00, lock_combined_o}) >
                       {1'b0, lock_thresh};
          hi_cnt <= 7'h00;
          win_cnt <= 7'h00;
        end else begin
          hi_cnt <= hi_cnt + {6'h00, lock_combined_o};
          win_cnt <= win_cnt + 7'h1;
        end
      end
    end
  end

  // Read preamble for normal commands
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      preamble_o <= 8'h00;
      preamble_valid_o <= 1'b0;
    end else begin
      preamble_valid_o <= is_norm;
      if (is_norm) begin
        preamble_o <= {`SBLC_PREAMBLE_HI, cmd_third_byte_i[1:0], 1'b0, lock_filt};
      end
    end
  end
endmodule

// File: test/sblc_top_asserts.sv
// Port-level checks for the synthesiser bus and lock control block
`timescale 1ns/10ps
module sblc_top_asserts (
  input wire       core_clk_i,
  input wire       rstn_i,
  input wire       synth_latch_strobe_i,
  input wire       cmd_valid_i,
  input wire [7:0] cmd_payload_byte_i,
  input wire [7:0] cmd_second_byte_i,
  input wire [7:0] cmd_third_byte_i,
  input wire       main_standby_bit_o,
  input wire       aux_standby_bit_o,
  input wire       speedup_active_o,
  input wire       sleep_o,
  input wire [7:0] dout_level_o,
  input wire [8:0] dout_oe_n_o,
  input wire       dout8_ref_on_o,
  input wire [7:0] preamble_o,
  input wire       preamble_valid_o,
  input wire       lock_combined_o
);
  wire [1:0] kind = cmd_second_byte_i[7:6];
  wire [1:0] ysel = cmd_third_byte_i[1:0];
  wire       ref8 = cmd_third_byte_i[5];
  wire       norm = cmd_valid_i && kind == 2'h1;
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);
  sequence s_normal;
    norm;
  endsequence
  // Two-stage synchroniser plus edge logic settles well inside four cycles
  sequence s_strobe_low;
    !synth_latch_strobe_i [*4];
  endsequence
  a_sleep_levels: assert property (
    sleep_o |-> dout_level_o == 8'h0C && dout_oe_n_o == 9'h110)
    else $error("sleep output levels wrong");
  a_preamble_word: assert property (
    s_normal |=> preamble_valid_o && preamble_o[7:1] == {4'hA, $past(ysel), 1'b0})
    else $error("preamble word wrong");
  a_answer_cause: assert property (
    preamble_valid_o |-> $past(norm))
    else $error("preamble without normal command");
  a_dout_load: assert property (
    s_normal ##0 cmd_second_byte_i[2] |=> dout_level_o == $past(cmd_payload_byte_i))
    else $error("digital outputs not loaded");
  a_dout8_copy: assert property (
    s_normal |=> dout8_ref_on_o == $past(ref8))
    else $error("output 8 not copied");
  a_normal_wake: assert property (
    s_normal |=> !sleep_o)
    else $error("normal command left sleep on");
  a_restart_sleep: assert property (
    cmd_valid_i && kind == 2'h2 && ysel == 2'h3 |=> sleep_o)
    else $error("restart did not reset");
  a_sleep_cmd: assert property (
    cmd_valid_i && kind == 2'h0 |=> sleep_o)
    else $error("sleep command ignored");
  a_lock_standby: assert property (
    main_standby_bit_o && aux_standby_bit_o |-> !lock_combined_o)
    else $error("lock high with both loops down");
  a_speedup_off: assert property (
    s_strobe_low |-> !speedup_active_o)
    else $error("speed-up with strobe low");
endmodule
bind sblc_top sblc_top_asserts u_chk (.core_clk_i, .rstn_i, .synth_latch_strobe_i,
  .cmd_valid_i, .cmd_payload_byte_i, .cmd_second_byte_i, .cmd_third_byte_i,
  .main_standby_bit_o, .aux_standby_bit_o, .speedup_active_o, .sleep_o, .dout_level_o,
  .dout_oe_n_o, .dout8_ref_on_o, .preamble_o, .preamble_valid_o, .lock_combined_o);

// File: test/sblc_mcu_model.sv
// Controller model driving the synthesiser serial bus
`timescale 1ns/10ps
module sblc_mcu_model (
  input  wire core_clk_i,
  output reg  bus_serial_clock_o,
  output reg  serial_data_o,
  output reg  synth_latch_strobe_o
);
  integer i;
  initial begin
    bus_serial_clock_o = 1'b0;
    serial_data_o = 1'b1;
    synth_latch_strobe_o = 1'b1;
  end
  // Twenty core cycles per half bus period, close to the nominal bus rate
  task half;
    repeat (20) @(negedge core_clk_i);
  endtask
  task send(input [33:0] w, input integer n, input integer h);
    begin
      @(negedge core_clk_i);
      synth_latch_strobe_o = 1'b0;
      for (i = n - 1; i >= 0; i = i - 1) begin
        serial_data_o = w[i];
        half;
        bus_serial_clock_o = 1'b1;
        half;
        bus_serial_clock_o = 1'b0;
      end
      // Released line must not keep showing the last bit
      serial_data_o = ~w[0];
      half;
      synth_latch_strobe_o = 1'b1;
      repeat (h) @(negedge core_clk_i);
    end
  endtask
  task tick(input integer n);
    repeat (n) begin
      half;
      bus_serial_clock_o = 1'b1;
      half;
      bus_serial_clock_o = 1'b0;
    end
  endtask
endmodule

// File: test/sblc_top_bench.sv
// Self-checking bench for the synthesiser bus and lock control block
`timescale 1ns/10ps
module sblc_top_bench;
  reg         clk, rstn, cv, xo, mrl, arl, edg;
  reg  [7:0]  pay, sec, thi;
  integer     bad_count, check_count, cyc;
  wire        sclk, sdat, stb, spd, slp, xon, con, mdf, d8, pv, lk, mst, ast, fdn, lgw;
  wire [1:0]  msl, asl, kl;
  wire [2:0]  nf;
  wire [3:0]  kk;
  wire [7:0]  nh, cn, dl, pre;
  wire [8:0]  oe;
  wire [11:0] nl, na, nr;
  sblc_mcu_model u_mcu (.core_clk_i(clk), .bus_serial_clock_o(sclk), .serial_data_o(sdat),
    .synth_latch_strobe_o(stb));
  sblc_top dut (.core_clk_i(clk), .rstn_i(rstn), .bus_serial_clock_i(sclk),
    .serial_data_i(sdat), .synth_latch_strobe_i(stb), .cmd_valid_i(cv),
    .cmd_payload_byte_i(pay), .cmd_second_byte_i(sec), .cmd_third_byte_i(thi),
    .crystal_reference_clock_i(xo), .main_ref_edge_i(edg), .main_div_edge_i(edg),
    .aux_ref_edge_i(edg), .aux_div_edge_i(edg), .main_reload_i(mrl), .aux_reload_i(arl),
    .main_low_modulus_count_o(nl), .main_high_modulus_count_o(nh), .frac_numerator_o(nf),
    .pump_scale_coeff_o(cn), .speedup_int_mult_o(kk), .speedup_prop_exp_o(kl),
    .aux_vco_divider_o(na), .reference_divider_o(nr), .main_compare_freq_sel_o(msl),
    .main_standby_bit_o(mst), .aux_compare_freq_sel_o(asl), .aux_standby_bit_o(ast),
    .frac_denominator_sel_o(fdn), .long_word_select_o(lgw), .speedup_active_o(spd),
    .sleep_o(slp), .xtal_osc_on_o(xon), .clk_out_osc_on_o(con), .mult_default_o(mdf),
    .dout_level_o(dl), .dout_oe_n_o(oe), .dout8_ref_on_o(d8), .preamble_o(pre),
    .preamble_valid_o(pv), .lock_combined_o(lk));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(negedge clk) xo <= ~xo;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count = bad_count + 1;
      summarize;
    end
  end
  task summarize;
    begin
      if (bad_count == 0 && check_count > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input [63:0] got, input [63:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task cmd(input [7:0] p, input [7:0] s, input [7:0] t);
    begin
      @(negedge clk);
      pay = p;
      sec = s;
      thi = t;
      cv = 1'b1;
      @(negedge clk);
      cv = 1'b0;
    end
  endtask
  task reload;
    begin
      @(negedge clk);
      mrl = 1'b1;
      arl = 1'b1;
      @(negedge clk);
      mrl = 1'b0;
      arl = 1'b0;
      repeat (2) @(negedge clk);
    end
  endtask
  task t_reset;
    begin
      chk({slp, xon, con, mdf, mst, ast}, 6'h3F);
      chk({dl, oe, lk}, {8'h0C, 9'h110, 1'b0});
    end
  endtask
  task t_cmds;
    begin
      cmd(8'hA5, 8'h44, 8'h22);
      chk({pv, pre[7:1]}, {1'b1, 4'hA, 2'h2, 1'b0});
      chk({slp, dl, d8}, {1'b0, 8'hA5, 1'b1});
      cmd(8'h3C, 8'h40, 8'h01);
      chk({dl, d8}, {8'hA5, 1'b0});
      cmd(8'h00, 8'h80, 8'h00);
      chk(slp, 1'b0);
      cmd(8'h00, 8'h80, 8'h03);
      chk({slp, dl}, {1'b1, 8'h0C});
      cmd(8'hFF, 8'h44, 8'h00);
      cmd(8'h00, 8'h00, 8'h00);
      chk({slp, dl, oe}, {1'b1, 8'h0C, 9'h110});
    end
  endtask
  task t_synth;
    begin
      u_mcu.send(32'h22B, 24, 8);
      chk({msl, mst, asl, ast, fdn, lgw}, 8'h8A);
      u_mcu.send(32'hFFFFFF, 24, 8);
      u_mcu.send(32'hF, 4, 8);
      chk({msl, mst, asl, ast, fdn, lgw}, 8'h8A);
      u_mcu.send({6'h0, 12'h5A3, 12'h0F8, 2'h2}, 26, 8);
      chk({na, nr}, {12'h003, 12'h008});
      reload;
      chk({na, nr}, {12'h5A3, 12'h0F8});
      u_mcu.send({6'h0, 8'h5A, 4'hF, 2'h3, 8'h00, 2'h1}, 26, 8);
      chk({cn, kk, kl}, 14'h0000);
      // Long hold stands for a real speed-up period
      u_mcu.send({6'h0, 12'hFFF, 8'h01, 3'h7, 3'h0}, 26, 200);
      chk({spd, cn, kk, kl}, {1'b1, 14'h16BF});
      chk(nl, 12'h003);
      reload;
      chk({nl, nh, nf}, {12'hFFF, 8'h01, 3'h7});
      u_mcu.send(32'hF, 4, 8);
      chk(spd, 1'b0);
      u_mcu.send(32'h227, 24, 8);
      u_mcu.send({8'h33, 12'h003, 8'hFF, 3'h0, 3'h0}, 34, 8);
      reload;
      chk({lgw, cn, nl, nh}, {1'b1, 8'h33, 12'h003, 8'hFF});
    end
  endtask
  task t_lock;
    begin
      u_mcu.send(32'h2BB, 24, 8);
      chk(lk, 1'b0);
      cmd(8'h20, 8'h80, 8'h20);
      cmd(8'h00, 8'h50, 8'h00);
      u_mcu.tick(180);
      cmd(8'h00, 8'h40, 8'h03);
      chk(pre, {4'hA, 2'h3, 1'b0, 1'b0});
      // Matched divider and reference edges keep both loops in lock
      edg = 1'b1;
      u_mcu.send(32'h203, 24, 8);
      chk(lk, 1'b1);
      cmd(8'hA4, 8'h50, 8'h00);
      u_mcu.tick(340);
      cmd(8'h00, 8'h40, 8'h02);
      chk(pre, {4'hA, 2'h2, 1'b0, 1'b1});
      cmd(8'hFE, 8'h50, 8'h00);
      u_mcu.tick(180);
      cmd(8'h00, 8'h40, 8'h01);
      chk(pre, {4'hA, 2'h1, 1'b0, 1'b0});
    end
  endtask
  initial begin
    rstn = 1'b0;
    cv = 1'b0;
    xo = 1'b0;
    mrl = 1'b0;
    arl = 1'b0;
    edg = 1'b0;
    pay = 8'h00;
    sec = 8'h00;
    thi = 8'h00;
    bad_count = 0;
    check_count = 0;
    cyc = 0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    t_reset;
    t_cmds;
    t_synth;
    t_lock;
    summarize;
  end
endmodule
